// [tesf_pkg.sv]
// Contract
// - the brake flag is set when the brake input shows its active level and holds until software clears it.
// - the commutation flag is set whenever a commutation event updates the channel output enable and mode fields.
// - in output mode channel 1 flag is set on a compare match, except in centre-aligned counting.
// - in input mode channel 1 flag is set when a capture loads capture register 1.
// - in input mode channel 1 flag is cleared by a software clear or by a read of capture register 1.
// - channels 2, 3 and 4 have the same event flags at status bits 2, 3 and 4.
// - the update flag is set whenever an update event is generated and holds until software clears it.
// - with update disable at 0, a repetition counter overflow or underflow generates an update event.
// - with update source select and update disable at 0, update generate or a software reinit generates an update.
// - with update source select and update disable at 0, a trigger reinit of the counter generates an update.
package tesf_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  STATUS_ADDR  = 8'h00;
  localparam logic [7:0]  ENABLE_ADDR  = 8'h04;
  localparam logic [7:0]  CLEAR_ADDR   = 8'h08;
  localparam logic [7:0]  CONTROL_ADDR = 8'h0c;
  localparam logic [7:0]  SWEVENT_ADDR = 8'h10;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int          UPD_BIT      = 0;
  localparam int          CH1_BIT      = 1;
  localparam int          COM_BIT      = 5;
  localparam int          TRG_BIT      = 6;
  localparam int          BRK_BIT      = 7;
  localparam int          UPDATE_DISABLE_BIT     = 0;
  localparam int          URS_BIT      = 1;
  localparam int          GATED_BIT    = 2;
  localparam int          CENTER_BIT   = 3;
  localparam int          TRGPOL_BIT   = 4;
  localparam int          BRKPOL_BIT   = 5;
  localparam int          CHIN_LSB     = 8;
  localparam int          UG_BIT       = 0;
  localparam int          REINIT_BIT   = 1;

  localparam logic [15:0] STATUS_RST   = 16'h0000;
  localparam logic [15:0] FLAG_MASK    = 16'h00ff;
  localparam logic [15:0] CONTROL_RST  = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic       brake;
    logic       trigger;
    logic       com_update;
    logic [3:0] cmp_match;
    logic [3:0] capture;
    logic [3:0] capture_read;
    logic       rep_wrap;
    logic       trig_reinit;
  } tesf_evt_t;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] enable;
    logic [15:0] control;
    logic [2:0]  brk_sync;
    logic [2:0]  trg_sync;
    logic        irq;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        have_aw;
    logic        have_w;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
  } tesf_state_t;

endpackage : tesf_pkg

// [tesf_flags.sv]
module tesf_flags (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               brake_in,
  input  wire logic               trigger_input,
  input  wire tesf_pkg::tesf_evt_t evt,
  output logic                    irq,
  output logic                    update_event,
  output logic [3:0]              chan_input_mode,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  tesf_pkg::tesf_state_t s_r;
  tesf_pkg::tesf_state_t s_nxt;
  logic                  upd_r;
  logic                  update_nxt_hold;

  // ----------------------------------------
  // byte-lane merge
  // ----------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = d[7:0];
    end
    if (st[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge16

  // ----------------------------------------
  // state update
  // ----------------------------------------
  always_comb begin
    logic        wr_go;
    logic        rd_go;
    logic        update_disable;
    logic        update_source_select;
    logic        brk_lvl;
    logic        trg_now;
    logic        trg_prev;
    logic        trg_edge;
    logic        ug;
    logic        sw_reinit;
    logic        upd;
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic [15:0] wmask;
    s_nxt     = s_r;
    wr_go     = 1'b0;
    rd_go     = 1'b0;
    ug        = 1'b0;
    sw_reinit = 1'b0;
    set_v     = 16'h0000;
    clr_v     = 16'h0000;
    wmask     = 16'h0000;
    brk_lvl   = 1'b0;
    trg_now   = 1'b0;
    trg_prev  = 1'b0;
    trg_edge  = 1'b0;
    upd       = 1'b0;
    update_disable      = s_r.control[tesf_pkg::UPDATE_DISABLE_BIT];
    update_source_select       = s_r.control[tesf_pkg::URS_BIT];
    s_nxt.brk_sync = {s_r.brk_sync[1:0], brake_in};
    s_nxt.trg_sync = {s_r.trg_sync[1:0], trigger_input};
    brk_lvl   = s_r.brk_sync[1] ^ ~s_r.control[tesf_pkg::BRKPOL_BIT];
    trg_now   = s_r.trg_sync[1] ^ s_r.control[tesf_pkg::TRGPOL_BIT];
    trg_prev  = s_r.trg_sync[2] ^ s_r.control[tesf_pkg::TRGPOL_BIT];
    if (s_r.control[tesf_pkg::GATED_BIT]) begin
      trg_edge = trg_now ^ trg_prev;
    end else begin
      trg_edge = trg_now & ~trg_prev;
    end
    // write channel
    s_nxt.awready = 1'b0;
    s_nxt.wready  = 1'b0;
    if (s_axi_awvalid && !s_r.have_aw && !s_r.awready && !s_r.bvalid) begin
      s_nxt.awready = 1'b1;
      s_nxt.have_aw = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.have_w && !s_r.wready && !s_r.bvalid) begin
      s_nxt.wready = 1'b1;
      s_nxt.have_w = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.have_aw && s_r.have_w && !s_r.bvalid) begin
      wr_go         = 1'b1;
      s_nxt.have_aw = 1'b0;
      s_nxt.have_w  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = tesf_pkg::RESP_OKAY;
      wmask = merge16(16'h0000, 32'hffffffff, s_r.w_strb) & tesf_pkg::FLAG_MASK;
      if (s_r.aw_addr == tesf_pkg::STATUS_ADDR) begin
        clr_v = wmask & ~s_r.w_data[15:0];
      end else if (s_r.aw_addr == tesf_pkg::CLEAR_ADDR) begin
        clr_v = wmask & s_r.w_data[15:0];
      end else if (s_r.aw_addr == tesf_pkg::ENABLE_ADDR) begin
        s_nxt.enable = merge16(s_r.enable, s_r.w_data, s_r.w_strb) & tesf_pkg::FLAG_MASK;
      end else if (s_r.aw_addr == tesf_pkg::CONTROL_ADDR) begin
        s_nxt.control = merge16(s_r.control, s_r.w_data, s_r.w_strb);
      end else if (s_r.aw_addr == tesf_pkg::SWEVENT_ADDR) begin
        ug        = s_r.w_strb[0] & s_r.w_data[tesf_pkg::UG_BIT];
        sw_reinit = s_r.w_strb[0] & s_r.w_data[tesf_pkg::REINIT_BIT];
      end else begin
        s_nxt.bresp = tesf_pkg::RESP_SLVERR;
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // read channel
    s_nxt.arready = 1'b0;
    if (s_axi_arvalid && !s_r.arready && !s_r.rvalid) begin
      rd_go         = 1'b1;
      s_nxt.arready = 1'b1;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rresp   = tesf_pkg::RESP_OKAY;
      s_nxt.rdata   = 32'h00000000;
      if (s_axi_araddr == tesf_pkg::STATUS_ADDR) begin
        s_nxt.rdata[15:0] = s_r.status;
      end else if (s_axi_araddr == tesf_pkg::ENABLE_ADDR) begin
        s_nxt.rdata[15:0] = s_r.enable;
      end else if (s_axi_araddr == tesf_pkg::CLEAR_ADDR) begin
        s_nxt.rdata = 32'h00000000;
      end else if (s_axi_araddr == tesf_pkg::CONTROL_ADDR) begin
        s_nxt.rdata[15:0] = s_r.control;
      end else if (s_axi_araddr == tesf_pkg::SWEVENT_ADDR) begin
        s_nxt.rdata = 32'h00000000;
      end else begin
        s_nxt.rresp = tesf_pkg::RESP_SLVERR;
      end
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // update event sources
    upd = (~update_disable & evt.rep_wrap)
        | (~update_disable & ~update_source_select & (ug | sw_reinit))
        | (~update_disable & ~update_source_select & evt.trig_reinit);
    // set sources
    set_v[tesf_pkg::BRK_BIT] = brk_lvl;
    set_v[tesf_pkg::TRG_BIT] = trg_edge | evt.trigger;
    set_v[tesf_pkg::COM_BIT] = evt.com_update;
    set_v[tesf_pkg::UPD_BIT] = upd;
    for (int i = 0; i < 4; i++) begin
      if (s_r.control[tesf_pkg::CHIN_LSB + i]) begin
        set_v[tesf_pkg::CH1_BIT + i] = evt.capture[i];
        clr_v[tesf_pkg::CH1_BIT + i] = clr_v[tesf_pkg::CH1_BIT + i] | evt.capture_read[i];
      end else begin
        set_v[tesf_pkg::CH1_BIT + i] = evt.cmp_match[i] & ~s_r.control[tesf_pkg::CENTER_BIT];
      end
    end
    // set wins over clear
    s_nxt.status = ((s_r.status & ~clr_v) | set_v) & tesf_pkg::FLAG_MASK;
    s_nxt.irq    = |(s_nxt.status & s_r.enable);
    if (wr_go || rd_go) begin
      s_nxt.irq = |(s_nxt.status & s_nxt.enable);
    end
    update_nxt_hold = upd;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r         <= '0;
      // idle level of the active-low brake pin, no false brake after reset
      s_r.brk_sync <= 3'h7;
      s_r.status  <= tesf_pkg::STATUS_RST;
      s_r.control <= tesf_pkg::CONTROL_RST;
      upd_r       <= 1'b0;
    end else begin
      s_r   <= s_nxt;
      upd_r <= update_nxt_hold;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign irq             = s_r.irq;
  assign update_event    = upd_r;
  assign chan_input_mode = s_r.control[tesf_pkg::CHIN_LSB +: 4];
  assign s_axi_awready   = s_r.awready;
  assign s_axi_wready    = s_r.wready;
  assign s_axi_bvalid    = s_r.bvalid;
  assign s_axi_bresp     = s_r.bresp;
  assign s_axi_arready   = s_r.arready;
  assign s_axi_rvalid    = s_r.rvalid;
  assign s_axi_rdata     = s_r.rdata;
  assign s_axi_rresp     = s_r.rresp;

endmodule : tesf_flags

// [tesf_flags_sva.sv]
module tesf_flags_sva (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire tesf_pkg::tesf_evt_t evt,
  input wire logic                irq,
  input wire logic                update_event,
  input wire logic [7:0]          s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // bus and flag checks
  // ----------------------------------------
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered");
  rd_error_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid && s_axi_araddr > 8'h10
    |=> s_axi_rresp == tesf_pkg::RESP_SLVERR) else $error("unmapped read not refused");
  wr_answer_a: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper bits set");
  upd_cause_a: assert property (update_event |-> $past(evt.rep_wrap) || $past(evt.trig_reinit)
    || $past(s_axi_wready) || $past(s_axi_wready, 2)) else $error("update without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(s_axi_wready) || $past(s_axi_wready, 2)
    || $past(s_axi_wready, 3) || $past(evt.capture_read, 2) != 4'h0 || $past(evt.capture_read) != 4'h0)
    else $error("irq dropped without clear");
endmodule : tesf_flags_sva

bind tesf_flags tesf_flags_sva u_sva (.aclk, .aresetn, .evt, .irq, .update_event, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready);

// [tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                aclk, aresetn, brake_in, trigger_input, irq, update_event;
  logic                s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp, rresp, bresp;
  logic [3:0]          s_axi_wstrb, chan_input_mode;
  logic [7:0]          s_axi_awaddr, s_axi_araddr;
  logic [31:0]         s_axi_wdata, s_axi_rdata, d;
  tesf_pkg::tesf_evt_t evt;
  int                  errors, compares, upd_n, n;
  int                  uc[9] = '{1, 1, 0, 2, 2, 2, 0, 0, 0};
  int                  us[9] = '{0, 1, 0, 0, 1, 3, 1, 2, 3};
  int                  ue[9] = '{0, 0, 1, 1, 0, 0, 1, 1, 1};
  int                  tc[6] = '{0, 0, 4, 4, 16, 16};
  int                  te[6] = '{1, 0, 1, 1, 0, 1};

  tesf_flags dut (.aclk, .aresetn, .brake_in, .trigger_input, .evt, .irq, .update_event, .chan_input_mode,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk) if (update_event === 1'h1) upd_n <= upd_n + 1;

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(ta && tw)) begin
      @(posedge aclk);
      ta |= (s_axi_awready === 1'h1);
      tw |= (s_axi_wready === 1'h1);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    bresp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    d = s_axi_rdata;
    rresp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string s);
    rd(a);
    chk(s, e, d);
  endtask : rc

  // event bits: brake, trigger, com, cmp[4], cap[4], capread[4], rep, treinit
  task automatic pulse(input logic [16:0] v);
    @(posedge aclk) evt <= tesf_pkg::tesf_evt_t'(v);
    @(posedge aclk) evt <= '0;
  endtask : pulse

  task automatic results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    results();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {aresetn, trigger_input, evt, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    brake_in = 1'h1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rc(tesf_pkg::STATUS_ADDR, 32'h0, "status");
    rc(tesf_pkg::ENABLE_ADDR, 32'h0, "enable");
    rc(tesf_pkg::CONTROL_ADDR, 32'h0, "control");
    rd(8'h40);
    chk("unmapped resp", tesf_pkg::RESP_SLVERR, rresp);
    wr(8'h40, 32'h0);
    chk("unmapped wresp", tesf_pkg::RESP_SLVERR, bresp);
    wr(tesf_pkg::ENABLE_ADDR, 32'h0);
    chk("mapped wresp", tesf_pkg::RESP_OKAY, bresp);
    $display("test reset done");
    pulse(17'h0fc02);
    brake_in <= 1'h0;
    repeat (6) @(posedge aclk);
    chk("irq masked", 1'h0, irq);
    rc(tesf_pkg::STATUS_ADDR, 32'hff, "all flags");
    wr(tesf_pkg::ENABLE_ADDR, 32'h80);
    repeat (3) @(posedge aclk);
    chk("irq on", 1'h1, irq);
    brake_in <= 1'h1;
    repeat (6) @(posedge aclk);
    wr(tesf_pkg::STATUS_ADDR, 32'hfe);
    rc(tesf_pkg::STATUS_ADDR, 32'hfe, "update clear");
    wr(tesf_pkg::CLEAR_ADDR, 32'h80);
    rc(tesf_pkg::STATUS_ADDR, 32'h7e, "brake clear");
    rc(tesf_pkg::CLEAR_ADDR, 32'h0, "clear reg");
    chk("irq off", 1'h0, irq);
    wr(tesf_pkg::STATUS_ADDR, 32'h0);
    wr(tesf_pkg::CONTROL_ADDR, 32'h8);
    pulse(17'h00400);
    rc(tesf_pkg::STATUS_ADDR, 32'h0, "centre compare");
    wr(tesf_pkg::CONTROL_ADDR, 32'hf00);
    pulse(17'h003c0);
    chk("input mode", 32'hf, chan_input_mode);
    rc(tesf_pkg::STATUS_ADDR, 32'h1e, "captures");
    pulse(17'h00004);
    rc(tesf_pkg::STATUS_ADDR, 32'h1c, "capture read");
    $display("test flags done");
    for (int k = 0; k < 9; k++) begin
      wr(tesf_pkg::CONTROL_ADDR, uc[k]);
      wr(tesf_pkg::STATUS_ADDR, 32'h0);
      n = upd_n;
      case (us[k])
        0: pulse(17'h00002);
        1: wr(tesf_pkg::SWEVENT_ADDR, 32'h1);
        2: wr(tesf_pkg::SWEVENT_ADDR, 32'h2);
        default: pulse(17'h00001);
      endcase
      repeat (3) @(posedge aclk);
      rd(tesf_pkg::STATUS_ADDR);
      chk("update flag", ue[k], d[0]);
      chk("update pulse", ue[k], upd_n - n);
    end
    $display("test update done");
    for (int k = 0; k < 6; k++) begin
      wr(tesf_pkg::CONTROL_ADDR, tc[k]);
      repeat (4) @(posedge aclk);
      wr(tesf_pkg::STATUS_ADDR, 32'h0);
      trigger_input <= ~trigger_input;
      repeat (6) @(posedge aclk);
      rd(tesf_pkg::STATUS_ADDR);
      chk("trigger flag", te[k], d[6]);
    end
    $display("test trigger done");
    results();
  end
endmodule : tb_top
